// [design/srp_pkg.sv]
// Package with constants and carrier types for the secondary request and protection controller.
// What this block does
// - Secondary supply overcurrent in the run state commands restart or latch per option.
// - Regulate current by comparing sense voltage against internal threshold flag, except when the overload option is set.
// - Rectifier gate on only after own request and winding falling edge.
// - Sense above three times threshold suppresses rectifier drive until nominal.
// - Rectifier gate pulled low whenever secondary is not in control.
// - Gate pin open below capacitance threshold, connected above it.
// - Open gate pin stops cycle requests so auto-restart follows.
// - Gate pin grounded at start-up disables drive and open-pin protection.
// - Valley gating engages in discontinuous conduction, off in continuous.
// - In discontinuous conduction requests open only at winding sense peaks.
// - Valley gating lasts 20 us after detection, then requests anytime.
// - About 1 us blanking hides winding ringing below ground.
// - Feedback restart option: output below threshold past timer causes restart.
// - Overload option: timer, then 45 ms pause; recovery resumes requests.
// - Sense grounded, no feedback restart: overload frequency past on-time restarts.
// - Discontinuous-only option: no request before first resonant valley.
// - Regulation modulates cycle enabling and selects high or low current limit.
// - Enabled cycle keeps switch on until current limit for the state.
// - Gate off before request in continuous, on low drop in discontinuous.
// - Regulate output so divided feedback equals internal reference.
// - Primary supply overcurrent makes primary latch off or auto-restart.
// - Request followed by inhibit until falling edge, 30 us timeout.
package srp_pkg;
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned VALLEY_US = 20;
    localparam int unsigned BLANK_US = 1;
    localparam int unsigned INHIBIT_US = 30;
    localparam int unsigned PAUSE_MS = 45;
    localparam int unsigned VALLEY_CYC = VALLEY_US * (CLK_HZ / 1_000_000);
    localparam int unsigned BLANK_CYC = BLANK_US * (CLK_HZ / 1_000_000);
    localparam int unsigned INHIBIT_CYC = INHIBIT_US * (CLK_HZ / 1_000_000);
    localparam int unsigned PAUSE_CYC = PAUSE_MS * (CLK_HZ / 1_000);
    localparam int unsigned RESTART_TMR_CYC = 4_000_000;
    localparam int unsigned SYNC_W = 12;
    // Register map over APB.
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam int unsigned CTRL_LATCH = 0;
    localparam int unsigned CTRL_FBAR = 1;
    localparam int unsigned CTRL_OVL = 2;
    localparam int unsigned CTRL_DCMONLY = 3;
    localparam int unsigned CTRL_EN = 4;
    localparam logic [31:0] CTRL_RST = 32'h0000_0012;
    localparam logic [31:0] APB_UNMAPPED = 32'h0000_0000;

    typedef enum logic [2:0] {
        SRP_IDLE = 3'b000,
        SRP_RUN = 3'b001,
        SRP_PAUSE = 3'b010,
        SRP_FAULT = 3'b011
    } srp_state_t;

    // Raw comparator flags from the analog front end.
    typedef struct packed {
        logic in_control;
        logic bps_oc;
        logic cs_over;
        logic cs_surge;
        logic gate_cap_hi;
        logic gate_grounded;
        logic fwd_low;
        logic fwd_peak;
        logic sr_drop_low;
        logic fb_low;
        logic fb_below_ar;
        logic freq_ovl;
    } srp_flags_t;
endpackage

// [design/srp_timer.sv]
// Loadable down counter with a done flag.
`timescale 1ns/1ps
module srp_timer
    import srp_pkg::*;
#(
    parameter int unsigned W = 23
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic load_i,
    input wire logic run_i,
    input wire logic [W-1:0] value_i,
    output logic done_o
);
    logic [W-1:0] count;

    // Load has priority; the counter holds at zero so done stays a level.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            count <= '0;
        end else if (load_i) begin
            count <= value_i;
        end else if (run_i && count != '0) begin
            count <= count - 1'b1;
        end
    end

    assign done_o = (count == '0) && !load_i;
endmodule // srp_timer

// [design/srp_ctrl.sv]
// Top of the secondary request and protection controller.
`timescale 1ns/1ps
module srp_ctrl
    import srp_pkg::*;
#(
    parameter int unsigned PAUSE_CYCLES = PAUSE_CYC,
    parameter int unsigned RESTART_CYCLES = RESTART_TMR_CYC
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire srp_flags_t flags_i,
    output logic cycle_request_o,
    output logic sr_gate_o,
    output logic sr_pulldown_o,
    output logic high_limit_o,
    output logic fault_cmd_o,
    output logic latch_cmd_o
);
    // ==================================================
    // Input synchronisers
    logic [SYNC_W-1:0] sync_a;
    srp_flags_t f;
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            sync_a <= '0;
            f <= '0;
        end else begin
            sync_a <= flags_i;
            f <= sync_a;
        end
    end

    // ==================================================
    // Register bus
    logic [31:0] ctrl;
    srp_state_t state;
    logic open_pin, sr_disabled, discontinuous_conduction, valley_seen;
    logic apb_wr;
    assign apb_wr = psel_i && penable_i && pwrite_i;
    assign pready_o = 1'b1;
    assign pslverr_o = 1'b0;

    // Control word selects fault mode and options; zero-wait slave.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            ctrl <= CTRL_RST;
        end else if (apb_wr && paddr_i == REG_CTRL) begin
            ctrl <= {27'h000_0000, pwdata_i[4:0]};
        end
    end

    // Read data registered in the setup cycle so it is valid in access.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            prdata_o <= '0;
        end else if (psel_i && !penable_i) begin
            unique case (paddr_i)
                REG_CTRL: prdata_o <= ctrl;
                REG_STAT: prdata_o <= {24'h00_0000, valley_seen, discontinuous_conduction, sr_disabled, open_pin, 1'b0, state};
                default: prdata_o <= APB_UNMAPPED;
            endcase
        end
    end

    // ==================================================
    // Winding edge detection with blanking
    logic fwd_q, fall_raw, fall, blank_done, blank_ok, peak;
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            fwd_q <= 1'b0;
        end else begin
            fwd_q <= f.fwd_low;
        end
    end
    assign fall_raw = f.fwd_low && !fwd_q;

    // Ringing below ground right after an edge is ignored for the blank time.
    srp_timer #(.W(6)) u_blank (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .load_i(fall_raw && blank_ok),
        .run_i(1'b1),
        .value_i(6'(BLANK_CYC)),
        .done_o(blank_done)
    );
    // The done flag depends on the timer's own load, so the reload uses last cycle's copy to avoid a loop.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            blank_ok <= 1'b0;
        end else begin
            blank_ok <= blank_done;
        end
    end
    assign fall = fall_raw && blank_ok;
    assign peak = f.fwd_peak && blank_done;

    // ==================================================
    // Request inhibit after each request
    logic inhibit, inh_done;
    srp_timer #(.W(11)) u_inhibit (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .load_i(cycle_request_o),
        .run_i(1'b1),
        .value_i(11'(INHIBIT_CYC)),
        .done_o(inh_done)
    );
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            inhibit <= 1'b0;
        end else if (cycle_request_o) begin
            inhibit <= 1'b1;
        end else if (fall || inh_done) begin
            inhibit <= 1'b0;
        end
    end

    // ==================================================
    // Conduction mode and valley window
    logic valley_done;
    // A falling edge without a sense peak since the last one means continuous conduction.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            discontinuous_conduction <= 1'b0;
            valley_seen <= 1'b0;
        end else begin
            if (peak) begin
                discontinuous_conduction <= 1'b1;
                valley_seen <= 1'b1;
            end else if (fall) begin
                discontinuous_conduction <= valley_seen;
                valley_seen <= 1'b0;
            end
        end
    end
    logic dcm_q;
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            dcm_q <= 1'b0;
        end else begin
            dcm_q <= discontinuous_conduction;
        end
    end
    srp_timer #(.W(10)) u_valley (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .load_i(discontinuous_conduction && !dcm_q),
        .run_i(1'b1),
        .value_i(10'(VALLEY_CYC)),
        .done_o(valley_done)
    );
    logic window_ok;
    // Only peaks open the window while gating is live; afterwards any time.
    always_comb begin
        window_ok = 1'b1;
        if (discontinuous_conduction && !valley_done) begin
            window_ok = peak;
        end
        if (ctrl[CTRL_DCMONLY] && !valley_seen) begin
            window_ok = 1'b0;
        end
    end

    // ==================================================
    // Gate pin checks at start-up and in run
    logic strap_done;
    logic [1:0] strap_age;
    // The strap is taken only once both synchroniser stages hold pin values rather than their reset zeros.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            strap_age <= 2'h0;
            strap_done <= 1'b0;
            sr_disabled <= 1'b0;
        end else if (!strap_done) begin
            if (strap_age == 2'h2) begin
                strap_done <= 1'b1;
                sr_disabled <= f.gate_grounded;
            end else begin
                strap_age <= strap_age + 2'h1;
            end
        end
    end
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            open_pin <= 1'b0;
        end else if (strap_done && !sr_disabled && f.in_control) begin
            open_pin <= !f.gate_cap_hi;
        end
    end

    // ==================================================
    // Overload and restart timing
    logic pause_done, tmr_done, tmr_cond;
    // Pick the condition that the selected overload option watches.
    always_comb begin
        tmr_cond = 1'b0;
        if (ctrl[CTRL_FBAR]) begin
            tmr_cond = f.fb_below_ar;
        end else if (ctrl[CTRL_OVL]) begin
            tmr_cond = f.cs_over;
        end else begin
            tmr_cond = f.freq_ovl;
        end
    end
    srp_timer #(.W(23)) u_restart (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .load_i(!tmr_cond || state != SRP_RUN),
        .run_i(1'b1),
        .value_i(23'(RESTART_CYCLES)),
        .done_o(tmr_done)
    );
    srp_timer #(.W(21)) u_pause (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .load_i(state != SRP_PAUSE),
        .run_i(1'b1),
        .value_i(21'(PAUSE_CYCLES)),
        .done_o(pause_done)
    );

    // ==================================================
    // Request and fault state machine
    srp_state_t next_state;
    always_comb begin
        next_state = state;
        unique case (state)
            SRP_IDLE: if (f.in_control && ctrl[CTRL_EN]) next_state = SRP_RUN;
            SRP_RUN: begin
                if (!f.in_control) begin
                    next_state = SRP_IDLE;
                end else if (f.bps_oc || open_pin) begin
                    next_state = SRP_FAULT;
                end else if (tmr_done && ctrl[CTRL_OVL] && !ctrl[CTRL_FBAR]) begin
                    next_state = SRP_PAUSE;
                end else if (tmr_done) begin
                    next_state = SRP_FAULT;
                end
            end
            SRP_PAUSE: begin
                if (!f.cs_over) begin
                    next_state = SRP_RUN;
                end else if (pause_done) begin
                    next_state = SRP_FAULT;
                end
            end
            SRP_FAULT: if (!f.in_control) next_state = SRP_IDLE;
            default: next_state = SRP_IDLE;
        endcase
    end
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            state <= SRP_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Fault command is a one-cycle pulse on entry with bps_oc set; latch flag chooses the action.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            fault_cmd_o <= 1'b0;
            latch_cmd_o <= 1'b0;
        end else begin
            fault_cmd_o <= (next_state == SRP_FAULT) && (state != SRP_FAULT) && f.bps_oc;
            latch_cmd_o <= ctrl[CTRL_LATCH];
        end
    end

    // Feedback low enables a cycle; the fb_below_ar flag picks the limit level.
    logic want;
    assign want = f.fb_low && (f.cs_over == 1'b0 || ctrl[CTRL_OVL]);
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            cycle_request_o <= 1'b0;
            high_limit_o <= 1'b0;
        end else begin
            cycle_request_o <= (state == SRP_RUN) && (next_state == SRP_RUN) && want && !inhibit && window_ok
                && !cycle_request_o;
            high_limit_o <= want && f.fb_below_ar;
        end
    end

    // ==================================================
    // Rectifier gate drive
    logic req_seen;
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            req_seen <= 1'b0;
        end else if (cycle_request_o) begin
            req_seen <= 1'b1;
        end else if (fall) begin
            req_seen <= 1'b0;
        end
    end
    // Surge and loss of control cut the gate at once, before any turn-on term.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            sr_gate_o <= 1'b0;
        end else if (!f.in_control || sr_disabled || f.cs_surge) begin
            sr_gate_o <= 1'b0;
        end else if (fall && req_seen) begin
            sr_gate_o <= 1'b1;
        end else if ((discontinuous_conduction && f.sr_drop_low) || (want && !inhibit && window_ok)) begin
            // A pending request cuts the gate in either mode, so the rectifier never overlaps a primary cycle.
            sr_gate_o <= 1'b0;
        end
    end
    assign sr_pulldown_o = !f.in_control;

    // ==================================================
    // Assertions
    property p_pull;
        @(posedge mclk_i) disable iff (!rst_n_i) !f.in_control |=> !sr_gate_o;
    endproperty
    a_pull: assert property (p_pull) else $error("Gate high out of control.");
    property p_surge;
        @(posedge mclk_i) disable iff (!rst_n_i) f.cs_surge |=> !sr_gate_o;
    endproperty
    a_surge: assert property (p_surge) else $error("Gate high in surge.");
    property p_on;
        @(posedge mclk_i) disable iff (!rst_n_i) $rose(sr_gate_o) |-> $past(req_seen) && $past(fall);
    endproperty
    a_on: assert property (p_on) else $error("Gate on without request and edge.");
    property p_inh;
        @(posedge mclk_i) disable iff (!rst_n_i) cycle_request_o |=> !cycle_request_o;
    endproperty
    a_inh: assert property (p_inh) else $error("Back to back requests.");
    logic [10:0] inh_age;
    // Counts how long inhibit has stood; it saturates so it can never wrap back under the limit.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            inh_age <= 11'h000;
        end else if (!inhibit) begin
            inh_age <= 11'h000;
        end else if (inh_age != 11'h7FF) begin
            inh_age <= inh_age + 11'h001;
        end
    end
    property p_inh_end;
        @(posedge mclk_i) disable iff (!rst_n_i) inh_age <= 11'(INHIBIT_CYC + 2);
    endproperty
    a_inh_end: assert property (p_inh_end) else $error("Inhibit outlived timeout.");
    property p_fault;
        @(posedge mclk_i) disable iff (!rst_n_i) state == SRP_FAULT |-> !cycle_request_o;
    endproperty
    a_fault: assert property (p_fault) else $error("Request during fault.");
    property p_oc;
        @(posedge mclk_i) disable iff (!rst_n_i) state == SRP_RUN && f.bps_oc && f.in_control |=> fault_cmd_o;
    endproperty
    a_oc: assert property (p_oc) else $error("No fault command on overcurrent.");
    property p_dis;
        @(posedge mclk_i) disable iff (!rst_n_i) sr_disabled |-> !sr_gate_o && !open_pin;
    endproperty
    a_dis: assert property (p_dis) else $error("Drive active while disabled.");
    c_req: cover property (@(posedge mclk_i) disable iff (!rst_n_i) cycle_request_o);
    c_gate: cover property (@(posedge mclk_i) disable iff (!rst_n_i) $rose(sr_gate_o));
    c_pause: cover property (@(posedge mclk_i) disable iff (!rst_n_i) state == SRP_PAUSE ##1 state == SRP_RUN);
endmodule // srp_ctrl

// [dv/srp_primary_model.sv]
// Behavioural model of the primary-side switch controller that answers cycle requests.
`timescale 1ns/1ps
module srp_primary_model (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic req_i,
    input wire logic [7:0] delay_i,
    input wire logic ring_i,
    output logic fwd_low_o,
    output logic fwd_peak_o,
    output logic sr_drop_low_o
);
    int unsigned cnt;
    // ==========================================================
    // Switch cycle
    // A delay of zero models a primary that never answers, so the request timeout gets exercised.
    // Requests seen while the winding is still low are dropped, as a busy primary would do.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            cnt <= 0;
            fwd_low_o <= 1'b0;
            fwd_peak_o <= 1'b0;
            sr_drop_low_o <= 1'b0;
        end else begin
            fwd_peak_o <= 1'b0;
            if (cnt != 0) cnt <= cnt + 1;
            if (cnt != 0 && cnt == delay_i) fwd_low_o <= 1'b1;
            if (cnt == delay_i + 60) begin
                fwd_low_o <= 1'b0;
                sr_drop_low_o <= 1'b1;
            end
            if (cnt == delay_i + 70) fwd_peak_o <= ring_i;
            if (cnt == delay_i + 80) begin
                cnt <= 0;
                sr_drop_low_o <= 1'b0;
            end
            if (req_i && delay_i != 0 && !fwd_low_o) begin
                cnt <= 1;
                sr_drop_low_o <= 1'b0;
            end
        end
    end
endmodule // srp_primary_model

// [dv/srp_ctrl_tb.sv]
// Self-checking testbench for the secondary request and protection controller.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end
module srp_ctrl_tb;
    import srp_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, cycle_request, sr_gate, sr_pulldown, high_limit, fault_cmd, latch_cmd;
    logic p_fwd_low, p_fwd_peak, p_drop;
    logic [7:0] delay = 8'h05;
    logic ring = 1'b0;
    // Sense input tied to ground, so the over-threshold comparator starts quiet.
    srp_flags_t bench_flags = '{in_control: 1'b1, gate_cap_hi: 1'b1, fb_low: 1'b1, default: 1'b0};
    srp_flags_t dut_flags;
    int unsigned n_errors = 0, num_checks = 0, cyc = 0, last_req = 0, gap = 0, n_req = 0, n_gate = 0;
    logic gate_q = 1'b0, req_seen = 1'b0;
    // ==========================================================
    // Clock, flag assembly and instances
    initial begin
        forever #12.5 mclk = ~mclk;
    end
    always_comb begin
        dut_flags = bench_flags;
        dut_flags.fwd_low = p_fwd_low;
        dut_flags.fwd_peak = p_fwd_peak;
        dut_flags.sr_drop_low = p_drop;
    end
    srp_ctrl #(.PAUSE_CYCLES(50), .RESTART_CYCLES(100)) uut (.mclk_i(mclk), .rst_n_i(rst_n), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .flags_i(dut_flags), .cycle_request_o(cycle_request),
        .sr_gate_o(sr_gate), .sr_pulldown_o(sr_pulldown), .high_limit_o(high_limit), .fault_cmd_o(fault_cmd),
        .latch_cmd_o(latch_cmd));
    srp_primary_model prim (.mclk_i(mclk), .rst_n_i(rst_n), .req_i(cycle_request), .delay_i(delay),
        .ring_i(ring), .fwd_low_o(p_fwd_low), .fwd_peak_o(p_fwd_peak), .sr_drop_low_o(p_drop));
    // ==========================================================
    // Expectations and bus tasks
    function automatic logic [31:0] exp_ctrl(input logic [31:0] w);
        return w & 32'h0000_001F;
    endfunction
    function automatic logic exp_latch(input logic [31:0] c);
        return c[CTRL_LATCH];
    endfunction
    // The slave answers with no wait states, but the master still polls pready.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_cyc(input int unsigned n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic close_out();
        $display("Checks made: %0d, mismatches: %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ==========================================================
    // Monitor of requests and gate pulses, plus the hang limit.
    always @(posedge mclk) begin
        if (sr_gate === 1'b1 && gate_q === 1'b0) begin
            n_gate++;
            `CHK("gate_needs_request", 1'b1, req_seen)
            req_seen = 1'b0;
        end
        gate_q = sr_gate;
        if (cycle_request === 1'b1) begin
            `CHK("gate_off_at_request", 1'b0, sr_gate)
            n_req++;
            gap = cyc - last_req;
            last_req = cyc;
            req_seen = 1'b1;
        end
        cyc++;
        if (cyc > 40000) begin
            n_errors++;
            close_out();
        end
    end
    // ==========================================================
    // Main sequence
    initial begin
        logic [31:0] rd;
        logic [31:0] w;
        int unsigned i;
        void'($urandom(10));
        wait_cyc(8);
        rst_n <= 1'b1;
        apb(1'b0, REG_CTRL, 32'h0000_0000, rd);
        `CHK("ctrl_reset", CTRL_RST, rd)
        apb(1'b1, 8'h08, 32'hFFFF_FFFF, rd);
        apb(1'b0, 8'h08, 32'h0000_0000, rd);
        `CHK("unmapped", APB_UNMAPPED, rd)
        `CHK("no_slave_error", 1'b0, pslverr)
        for (i = 0; i < 4; i++) begin
            w = $urandom();
            apb(1'b1, REG_CTRL, w, rd);
            apb(1'b0, REG_CTRL, 32'h0000_0000, rd);
            `CHK("ctrl_rw", exp_ctrl(w), rd)
        end
        apb(1'b1, REG_CTRL, 32'h0000_0010, rd);
        delay <= 8'($urandom_range(20, 1));
        wait_cyc(2000);
        `CHK("requests_run", 1'b1, n_req > 0 && n_gate > 0)
        apb(1'b0, REG_STAT, 32'h0000_0000, rd);
        `CHK("state_run", 3'h1, rd[2:0])
        `CHK("pulldown_off", 1'b0, sr_pulldown)
        bench_flags.fb_below_ar <= 1'b1;
        wait_cyc(5);
        `CHK("high_limit", 1'b1, high_limit)
        bench_flags.fb_below_ar <= 1'b0;
        wait_cyc(5);
        `CHK("low_limit", 1'b0, high_limit)
        bench_flags.in_control <= 1'b0;
        wait_cyc(6);
        `CHK("pulldown_on", 1'b1, sr_pulldown)
        `CHK("gate_low_idle", 1'b0, sr_gate)
        bench_flags.in_control <= 1'b1;
        delay <= 8'h00;
        wait_cyc(3000);
        `CHK("inhibit_gap", 1'b1, gap >= INHIBIT_CYC && gap <= INHIBIT_CYC + 8)
        delay <= 8'($urandom_range(20, 1));
        ring <= 1'b1;
        wait_cyc(1500);
        apb(1'b0, REG_STAT, 32'h0000_0000, rd);
        `CHK("dcm_on", 1'b1, rd[6])
        ring <= 1'b0;
        wait_cyc(3000);
        apb(1'b0, REG_STAT, 32'h0000_0000, rd);
        `CHK("dcm_off", 1'b0, rd[6])
        // Discontinuous-only with no ringing: the last edge cleared the valley flag, so requests must stop.
        apb(1'b1, REG_CTRL, 32'h0000_0018, rd);
        wait_cyc(2);
        n_req = 0;
        wait_cyc(300);
        `CHK("dcm_only_hold", 0, n_req)
        apb(1'b1, REG_CTRL, 32'h0000_0010, rd);
        bench_flags.cs_surge <= 1'b1;
        wait_cyc(20);
        n_gate = 0;
        wait_cyc(1500);
        `CHK("surge_no_gate", 0, n_gate)
        bench_flags.cs_surge <= 1'b0;
        wait_cyc(1500);
        `CHK("surge_over", 1'b1, n_gate > 0)
        // Both fault responses, restart first and then latch-off.
        for (i = 0; i < 2; i++) begin
            w = 32'h0000_0010 | i;
            apb(1'b1, REG_CTRL, w, rd);
            bench_flags.bps_oc <= 1'b1;
            i = i + 0;
            repeat (10) if (fault_cmd !== 1'b1) @(posedge mclk);
            `CHK("fault_cmd", 1'b1, fault_cmd)
            `CHK("latch_cmd", exp_latch(w), latch_cmd)
            bench_flags.bps_oc <= 1'b0;
            apb(1'b0, REG_STAT, 32'h0000_0000, rd);
            `CHK("state_fault", 3'h3, rd[2:0])
            bench_flags.in_control <= 1'b0;
            wait_cyc(6);
            bench_flags.in_control <= 1'b1;
            wait_cyc(6);
        end
        apb(1'b1, REG_CTRL, 32'h0000_0010, rd);
        bench_flags.gate_cap_hi <= 1'b0;
        wait_cyc(1500);
        n_req = 0;
        wait_cyc(1500);
        `CHK("open_pin_stop", 0, n_req)
        apb(1'b0, REG_STAT, 32'h0000_0000, rd);
        `CHK("open_pin_flag", 1'b1, rd[4])
        bench_flags.gate_cap_hi <= 1'b1;
        bench_flags.in_control <= 1'b0;
        wait_cyc(6);
        bench_flags.in_control <= 1'b1;
        apb(1'b1, REG_CTRL, 32'h0000_0014, rd);
        wait_cyc(500);
        bench_flags.cs_over <= 1'b1;
        wait_cyc(110);
        n_req = 0;
        wait_cyc(30);
        `CHK("pause_quiet", 0, n_req)
        apb(1'b0, REG_STAT, 32'h0000_0000, rd);
        `CHK("state_pause", 3'h2, rd[2:0])
        bench_flags.cs_over <= 1'b0;
        wait_cyc(20);
        apb(1'b0, REG_STAT, 32'h0000_0000, rd);
        `CHK("pause_resume", 3'h1, rd[2:0])
        // Strap the gate pin to ground across a fresh reset.
        rst_n <= 1'b0;
        bench_flags.gate_grounded <= 1'b1;
        bench_flags.gate_cap_hi <= 1'b0;
        wait_cyc(8);
        rst_n <= 1'b1;
        wait_cyc(4);
        n_gate = 0;
        n_req = 0;
        wait_cyc(2000);
        `CHK("strap_no_gate", 0, n_gate)
        `CHK("strap_requests", 1'b1, n_req > 0)
        apb(1'b0, REG_STAT, 32'h0000_0000, rd);
        `CHK("strap_flags", 2'h2, rd[5:4])
        close_out();
    end
endmodule // srp_ctrl_tb
